// >>> pfd_pkg.sv
// Package for the peripheral frame decoder: address windows, types, resets
package pfd_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int ADDR_W = 22;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;

	// ---------------------------------------------------------------
	// Frame 0 windows (word addresses, inclusive)
	// ---------------------------------------------------------------
	localparam logic [21:0] EMU_LO = 22'h000880;
	localparam logic [21:0] EMU_HI = 22'h000984;
	localparam logic [21:0] PWR_LO = 22'h000985;
	localparam logic [21:0] PWR_HI = 22'h000987;
	localparam logic [21:0] FLASH_LO = 22'h000a80;
	localparam logic [21:0] FLASH_HI = 22'h000adf;
	localparam logic [21:0] KEY_LO = 22'h000ae0;
	localparam logic [21:0] KEY_HI = 22'h000aef;
	localparam logic [21:0] RESULT_LO = 22'h000b00;
	localparam logic [21:0] RESULT_HI = 22'h000b0f;
	localparam logic [21:0] TIMER_LO = 22'h000c00;
	localparam logic [21:0] TIMER_HI = 22'h000c3f;
	localparam logic [21:0] IRQCTL_LO = 22'h000ce0;
	localparam logic [21:0] IRQCTL_HI = 22'h000cff;
	localparam logic [21:0] VECTOR_LO = 22'h000d00;
	localparam logic [21:0] VECTOR_HI = 22'h000dff;

	// ---------------------------------------------------------------
	// Frame 1 windows
	// ---------------------------------------------------------------
	localparam logic [21:0] CMP_LO = 22'h006400;
	localparam logic [21:0] CMP_HI = 22'h00643f;
	localparam logic [21:0] PWM_LO = 22'h006800;
	localparam logic [21:0] PWM_HI = 22'h0068ff;
	localparam logic [21:0] CAP_LO = 22'h006a00;
	localparam logic [21:0] CAP_HI = 22'h006a1f;
	localparam logic [21:0] GPIO_LO = 22'h006f80;
	localparam logic [21:0] GPIO_HI = 22'h006fff;

	// ---------------------------------------------------------------
	// Frame 2 windows
	// ---------------------------------------------------------------
	localparam logic [21:0] SYS_LO = 22'h007010;
	localparam logic [21:0] SYS_HI = 22'h00702f;
	localparam logic [21:0] SER_LO = 22'h007040;
	localparam logic [21:0] SER_HI = 22'h00705f;
	localparam logic [21:0] WDI_LO = 22'h007060;
	localparam logic [21:0] WDI_HI = 22'h00706f;
	localparam logic [21:0] EXT_LO = 22'h007070;
	localparam logic [21:0] EXT_HI = 22'h00707f;
	localparam logic [21:0] CONV_LO = 22'h007100;
	localparam logic [21:0] CONV_HI = 22'h00717f;
	localparam logic [21:0] IIC_LO = 22'h007900;
	localparam logic [21:0] IIC_HI = 22'h00793f;

	// ---------------------------------------------------------------
	// Identity and configuration registers
	// ---------------------------------------------------------------
	localparam logic [21:0] DEVICE_CONFIG_OFS = 22'h000880;
	localparam logic [21:0] CLASS_CODE_OFS = 22'h000882;
	localparam logic [21:0] REVISION_CODE_OFS = 22'h000883;
	localparam logic [21:0] PART_CODE_OFS = 22'h3d7fff;
	localparam logic [31:0] DEVICE_CONFIG_RST = 32'h00000000;
	localparam logic [31:0] DEVICE_CONFIG_WMASK = 32'hffffffff;

	// Route of one access, one-hot
	typedef enum logic [4:0] {
		SEL_NONE = 5'b00001,
		SEL_F0 = 5'b00010,
		SEL_F1 = 5'b00100,
		SEL_F2 = 5'b01000,
		SEL_ID = 5'b10000
	} pfd_sel_e;

	// CPU side request
	typedef struct packed {
		logic rd;
		logic wr;
		logic wide;
		logic [21:0] addr;
		logic [31:0] wdata;
	} pfd_req_s;

	// Outcome of decoding one address
	typedef struct packed {
		pfd_sel_e sel;
		logic prot;
		logic flash;
		logic rdonly;
	} pfd_dec_s;

	// Request toward one peripheral frame
	typedef struct packed {
		logic rd;
		logic wr;
		logic wide;
		logic [21:0] addr;
		logic [31:0] wdata;
	} pfd_bus_s;

endpackage : pfd_pkg

// >>> pfd_window_decode.sv
// Address window decoder: frame choice and protection class of an address
module pfd_window_decode
(
	// Address in
	input wire logic [21:0] addr,
	// Decode out
	output pfd_pkg::pfd_dec_s dec
);

	// ---------------------------------------------------------------
	// Window test
	// ---------------------------------------------------------------
	function automatic logic in_win(input logic [21:0] a,
		input logic [21:0] lo, input logic [21:0] hi);
		in_win = (a >= lo) && (a <= hi);
	endfunction : in_win

	// Identity registers except the part code sit inside the emulation window, checked first
	wire hit_cfg = in_win(addr, pfd_pkg::DEVICE_CONFIG_OFS,
		pfd_pkg::DEVICE_CONFIG_OFS + 22'h000001);
	wire hit_cls = addr == pfd_pkg::CLASS_CODE_OFS;
	wire hit_rev = addr == pfd_pkg::REVISION_CODE_OFS;
	wire hit_part = addr == pfd_pkg::PART_CODE_OFS;
	wire hit_id = hit_cfg | hit_cls | hit_rev | hit_part;

	// Frame 0 windows
	wire hit_emu = in_win(addr, pfd_pkg::EMU_LO, pfd_pkg::EMU_HI);
	wire hit_pwr = in_win(addr, pfd_pkg::PWR_LO, pfd_pkg::PWR_HI);
	wire hit_flash = in_win(addr, pfd_pkg::FLASH_LO, pfd_pkg::FLASH_HI);
	wire hit_key = in_win(addr, pfd_pkg::KEY_LO, pfd_pkg::KEY_HI);
	wire hit_res = in_win(addr, pfd_pkg::RESULT_LO, pfd_pkg::RESULT_HI);
	wire hit_tmr = in_win(addr, pfd_pkg::TIMER_LO, pfd_pkg::TIMER_HI);
	wire hit_irq = in_win(addr, pfd_pkg::IRQCTL_LO, pfd_pkg::IRQCTL_HI);
	wire hit_vec = in_win(addr, pfd_pkg::VECTOR_LO, pfd_pkg::VECTOR_HI);
	wire hit_f0 = hit_emu | hit_pwr | hit_flash | hit_key | hit_res
		| hit_tmr | hit_irq | hit_vec;

	// Frame 1 windows
	wire hit_f1 = in_win(addr, pfd_pkg::CMP_LO, pfd_pkg::CMP_HI)
		| in_win(addr, pfd_pkg::PWM_LO, pfd_pkg::PWM_HI)
		| in_win(addr, pfd_pkg::CAP_LO, pfd_pkg::CAP_HI)
		| in_win(addr, pfd_pkg::GPIO_LO, pfd_pkg::GPIO_HI);

	// Frame 2 windows
	wire hit_sys = in_win(addr, pfd_pkg::SYS_LO, pfd_pkg::SYS_HI);
	wire hit_wdi = in_win(addr, pfd_pkg::WDI_LO, pfd_pkg::WDI_HI);
	wire hit_ext = in_win(addr, pfd_pkg::EXT_LO, pfd_pkg::EXT_HI);
	wire hit_f2 = hit_sys | hit_wdi | hit_ext
		| in_win(addr, pfd_pkg::SER_LO, pfd_pkg::SER_HI)
		| in_win(addr, pfd_pkg::CONV_LO, pfd_pkg::CONV_HI)
		| in_win(addr, pfd_pkg::IIC_LO, pfd_pkg::IIC_HI);

	// Route and protection class; identity wins over its host window
	assign dec.sel = hit_id ? pfd_pkg::SEL_ID :
		hit_f0 ? pfd_pkg::SEL_F0 :
		hit_f1 ? pfd_pkg::SEL_F1 :
		hit_f2 ? pfd_pkg::SEL_F2 : pfd_pkg::SEL_NONE;
	assign dec.prot = hit_cfg | ((hit_emu | hit_pwr | hit_flash | hit_key
		| hit_sys | hit_wdi | hit_ext) & ~hit_id);
	assign dec.flash = hit_flash;
	assign dec.rdonly = hit_res | hit_cls | hit_rev | hit_part;

endmodule : pfd_window_decode

// >>> pfd_id_regs.sv
// Device configuration word and read-only identity codes
module pfd_id_regs
#(
	// Arbitrary neutral identity values
	parameter logic [15:0] PART_CODE = 16'h1234,
	parameter logic [15:0] CLASS_CODE = 16'h0056,
	parameter logic [15:0] REVISION_CODE = 16'h0001
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Access, already cleared of blocked writes
	input wire logic rd,
	input wire logic wr,
	input wire logic wide,
	input wire logic [21:0] addr,
	input wire logic [31:0] wdata,
	// Results
	output logic [31:0] rdata,
	output logic [31:0] config_word
);

	logic [31:0] cfg_reg;
	logic [31:0] cfg_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// ---------------------------------------------------------------
	// Write merge: a 16-bit write at the upper word touches bits 31:16
	// ---------------------------------------------------------------
	wire cfg_lo_hit = addr == pfd_pkg::DEVICE_CONFIG_OFS;
	wire cfg_hi_hit = addr == (pfd_pkg::DEVICE_CONFIG_OFS + 22'h000001);
	wire [31:0] cfg_wmask = !wr ? 32'h00000000 :
		(cfg_lo_hit && wide) ? pfd_pkg::DEVICE_CONFIG_WMASK :
		cfg_lo_hit ? (pfd_pkg::DEVICE_CONFIG_WMASK & 32'h0000ffff) :
		cfg_hi_hit ? (pfd_pkg::DEVICE_CONFIG_WMASK & 32'hffff0000) :
		32'h00000000;
	wire [31:0] cfg_wdata = cfg_hi_hit ? {wdata[15:0], 16'h0000} : wdata;
	assign cfg_next = (cfg_reg & ~cfg_wmask) | (cfg_wdata & cfg_wmask);

	// Read mux; codes are fixed and ignore writes
	assign rdata_next = !rd ? 32'h00000000 :
		(cfg_lo_hit && wide) ? cfg_reg :
		cfg_lo_hit ? {16'h0000, cfg_reg[15:0]} :
		cfg_hi_hit ? {16'h0000, cfg_reg[31:16]} :
		(addr == pfd_pkg::CLASS_CODE_OFS) ? {16'h0000, CLASS_CODE} :
		(addr == pfd_pkg::REVISION_CODE_OFS) ? {16'h0000, REVISION_CODE} :
		(addr == pfd_pkg::PART_CODE_OFS) ? {16'h0000, PART_CODE} :
		32'h00000000;

	// Storage
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg_reg <= pfd_pkg::DEVICE_CONFIG_RST;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			cfg_reg <= cfg_next;
			rdata_reg <= rdata_next;
		end
	end

	assign rdata = rdata_reg;
	assign config_word = cfg_reg;

endmodule : pfd_id_regs

// >>> pfd_frame_decoder.sv
// Peripheral frame decoder: routes CPU register accesses, gates protected writes
module pfd_frame_decoder
#(
	// Identity values, arbitrary neutral codes
	parameter logic [15:0] PART_CODE = 16'h1234,
	parameter logic [15:0] CLASS_CODE = 16'h0056,
	parameter logic [15:0] REVISION_CODE = 16'h0001
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// CPU request and answer
	input pfd_pkg::pfd_req_s cpu_req,
	output logic [31:0] cpu_rdata,
	output logic cpu_ack,
	// CPU protection instructions, one-cycle pulses
	input wire logic write_unlock_instruction,
	input wire logic write_relock_instruction,
	// Code security unit lock state, high when unlocked
	input wire logic code_security_unit_open,
	// Frame 0, CPU memory bus
	output pfd_pkg::pfd_bus_s f0_bus,
	input wire logic [31:0] f0_rdata,
	// Frame 1, 32-bit peripheral bus
	output pfd_pkg::pfd_bus_s f1_bus,
	input wire logic [31:0] f1_rdata,
	// Frame 2, 16-bit peripheral bus
	output pfd_pkg::pfd_bus_s f2_bus,
	input wire logic [15:0] f2_rdata,
	// Status and configuration
	output logic write_unlocked,
	output logic [31:0] device_config
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	pfd_pkg::pfd_dec_s dec;
	logic unlock_reg;
	logic unlock_next;
	pfd_pkg::pfd_bus_s f0_reg;
	pfd_pkg::pfd_bus_s f1_reg;
	pfd_pkg::pfd_bus_s f2_reg;
	pfd_pkg::pfd_bus_s f0_next;
	pfd_pkg::pfd_bus_s f1_next;
	pfd_pkg::pfd_bus_s f2_next;
	pfd_pkg::pfd_sel_e sel_reg;
	pfd_pkg::pfd_sel_e sel_next;
	logic pend_reg;
	logic pend_next;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] id_rdata;
	logic [31:0] cfg_word;

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	pfd_window_decode u_decode
	(
		.addr(cpu_req.addr),
		.dec(dec)
	);

	// ---------------------------------------------------------------
	// Write gate
	// ---------------------------------------------------------------
	// Relock has the last word if both arrive together
	assign unlock_next = write_relock_instruction ? 1'b0 :
		write_unlock_instruction ? 1'b1 : unlock_reg;

	// Flash control needs the security unit open as well
	wire flash_ok = unlock_reg & code_security_unit_open;
	wire prot_ok = !dec.prot || unlock_reg;
	wire write_ok = cpu_req.wr && prot_ok && !dec.rdonly
		&& (!dec.flash || flash_ok);
	wire read_go = cpu_req.rd && !cpu_req.wr;
	wire any_req = cpu_req.rd || cpu_req.wr;

	// Per-frame selects from the decode alone; the rd and wr strobes built from them stay low for unmapped or blocked accesses
	wire go_f0 = dec.sel == pfd_pkg::SEL_F0;
	wire go_f1 = dec.sel == pfd_pkg::SEL_F1;
	wire go_f2 = dec.sel == pfd_pkg::SEL_F2;
	wire go_id = dec.sel == pfd_pkg::SEL_ID;

	// ---------------------------------------------------------------
	// Frame requests
	// ---------------------------------------------------------------
	// Frame 0 carries the width bit, both widths pass
	assign f0_next.rd = go_f0 & read_go;
	assign f0_next.wr = go_f0 & write_ok;
	assign f0_next.wide = go_f0 & cpu_req.wide;
	assign f0_next.addr = go_f0 ? cpu_req.addr : 22'h000000;
	assign f0_next.wdata = (go_f0 && write_ok) ? cpu_req.wdata : 32'h00000000;

	// Frame 1 is a 32-bit bus, width passes too
	assign f1_next.rd = go_f1 & read_go;
	assign f1_next.wr = go_f1 & write_ok;
	assign f1_next.wide = go_f1 & cpu_req.wide;
	assign f1_next.addr = go_f1 ? cpu_req.addr : 22'h000000;
	assign f1_next.wdata = (go_f1 && write_ok) ? cpu_req.wdata : 32'h00000000;

	// Frame 2 is 16 bits: upper half and width bit never leave
	assign f2_next.rd = go_f2 & read_go;
	assign f2_next.wr = go_f2 & write_ok;
	assign f2_next.wide = 1'b0;
	assign f2_next.addr = go_f2 ? cpu_req.addr : 22'h000000;
	assign f2_next.wdata = (go_f2 && write_ok) ?
		{16'h0000, cpu_req.wdata[15:0]} : 32'h00000000;

	// Remember the route of the access in flight
	assign sel_next = any_req ? dec.sel : pfd_pkg::SEL_NONE;
	assign pend_next = any_req;

	// ---------------------------------------------------------------
	// Identity and configuration
	// ---------------------------------------------------------------
	// The configuration word sits in the emulation window, so it is gated
	pfd_id_regs
	#(
		.PART_CODE(PART_CODE),
		.CLASS_CODE(CLASS_CODE),
		.REVISION_CODE(REVISION_CODE)
	)
	u_id
	(
		.clock(clock),
		.sys_rst(sys_rst),
		.rd(go_id & read_go),
		.wr(go_id & write_ok),
		.wide(cpu_req.wide),
		.addr(cpu_req.addr),
		.wdata(cpu_req.wdata),
		.rdata(id_rdata),
		.config_word(cfg_word)
	);

	// ---------------------------------------------------------------
	// Read return
	// ---------------------------------------------------------------
	// Frames answer in the cycle their strobe stands; unmapped reads zero
	assign rdata_next = !pend_reg ? 32'h00000000 :
		(sel_reg == pfd_pkg::SEL_F0) ? f0_rdata :
		(sel_reg == pfd_pkg::SEL_F1) ? f1_rdata :
		(sel_reg == pfd_pkg::SEL_F2) ? {16'h0000, f2_rdata} :
		(sel_reg == pfd_pkg::SEL_ID) ? id_rdata :
		32'h00000000;

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Protection state
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			unlock_reg <= 1'b0;
		else
			unlock_reg <= unlock_next;
	end

	// Frame strobes, one cycle each
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			f0_reg <= '0;
			f1_reg <= '0;
			f2_reg <= '0;
		end
		else
		begin
			f0_reg <= f0_next;
			f1_reg <= f1_next;
			f2_reg <= f2_next;
		end
	end

	// Route tag for the read return
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sel_reg <= pfd_pkg::SEL_NONE;
			pend_reg <= 1'b0;
		end
		else
		begin
			sel_reg <= sel_next;
			pend_reg <= pend_next;
		end
	end

	// Every access is answered, blocked or not, so the CPU never hangs
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
		end
		else
		begin
			ack_reg <= pend_reg;
			rdata_reg <= rdata_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign f0_bus = f0_reg;
	assign f1_bus = f1_reg;
	assign f2_bus = f2_reg;
	assign cpu_ack = ack_reg;
	assign cpu_rdata = rdata_reg;
	assign write_unlocked = unlock_reg;
	assign device_config = cfg_word;

endmodule : pfd_frame_decoder

// >>> pfd_frame_decoder_sva.sv
// Assertion checker watching the ports of the peripheral frame decoder
module pfd_frame_decoder_sva
#(
	parameter logic [15:0] PART_CODE = 16'h1234,
	parameter logic [15:0] CLASS_CODE = 16'h0056,
	parameter logic [15:0] REVISION_CODE = 16'h0001
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// CPU side
	input pfd_pkg::pfd_req_s cpu_req,
	input wire logic [31:0] cpu_rdata,
	input wire logic cpu_ack,
	input wire logic write_unlock_instruction,
	input wire logic write_relock_instruction,
	input wire logic code_security_unit_open,
	// Frame buses
	input pfd_pkg::pfd_bus_s f0_bus,
	input wire logic [31:0] f0_rdata,
	input pfd_pkg::pfd_bus_s f1_bus,
	input wire logic [31:0] f1_rdata,
	input pfd_pkg::pfd_bus_s f2_bus,
	input wire logic [15:0] f2_rdata,
	// Status
	input wire logic write_unlocked,
	input wire logic [31:0] device_config
);
	// ---------------------------------------------------------------
	// Window decode of the request, from the package constants
	// ---------------------------------------------------------------
	wire logic [21:0] a = cpu_req.addr;
	wire logic rq = cpu_req.rd & ~cpu_req.wr;
	wire logic in_f1 = (a >= pfd_pkg::CMP_LO && a <= pfd_pkg::CMP_HI) ||
		(a >= pfd_pkg::PWM_LO && a <= pfd_pkg::PWM_HI) ||
		(a >= pfd_pkg::CAP_LO && a <= pfd_pkg::CAP_HI) ||
		(a >= pfd_pkg::GPIO_LO && a <= pfd_pkg::GPIO_HI);
	wire logic in_sys = a >= pfd_pkg::SYS_LO && a <= pfd_pkg::SYS_HI;
	wire logic in_fl = a >= pfd_pkg::FLASH_LO && a <= pfd_pkg::FLASH_HI;
	wire logic in_res = a >= pfd_pkg::RESULT_LO && a <= pfd_pkg::RESULT_HI;
	wire logic in_tmr = a >= pfd_pkg::TIMER_LO && a <= pfd_pkg::TIMER_HI;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	AST_ACK_LAT: assert property ((cpu_req.rd | cpu_req.wr) |-> ##2 cpu_ack)
		else $error("ack missing two cycles after request");
	AST_ACK_CAUSE: assert property (cpu_ack |-> $past(cpu_req.rd | cpu_req.wr, 2))
		else $error("ack without request");
	AST_F1_ROUTE: assert property (rq && in_f1 |=> f1_bus.rd &&
		f1_bus.addr == $past(a)) else $error("frame 1 read not routed");
	AST_F0_WIDE: assert property (rq && in_tmr |=> f0_bus.rd &&
		f0_bus.wide == $past(cpu_req.wide)) else $error("frame 0 width lost");
	AST_F2_NARROW: assert property ((f2_bus.rd | f2_bus.wr) |-> !f2_bus.wide &&
		f2_bus.wdata[31:16] == 16'h0) else $error("frame 2 not 16 bit");
	AST_SYS_LOCK: assert property (cpu_req.wr && in_sys && !write_unlocked
		|=> !f2_bus.wr) else $error("locked write passed");
	AST_SYS_OPEN: assert property (cpu_req.wr && in_sys && write_unlocked
		|=> f2_bus.wr && f2_bus.wdata[15:0] == $past(cpu_req.wdata[15:0]))
		else $error("unlocked write dropped");
	AST_FLASH: assert property (cpu_req.wr && in_fl && !(write_unlocked &&
		code_security_unit_open) |=> !f0_bus.wr) else $error("flash gate open");
	AST_RES_RO: assert property (cpu_req.wr && in_res |=> !f0_bus.wr)
		else $error("result write passed");
	AST_RELOCK: assert property (write_relock_instruction |=> !write_unlocked)
		else $error("relock ignored");
	AST_UNLOCK: assert property (write_unlock_instruction &&
		!write_relock_instruction |=> write_unlocked) else $error("unlock ignored");
	AST_CLASS: assert property (rq && a == pfd_pkg::CLASS_CODE_OFS |->
		##2 cpu_rdata == {16'h0, CLASS_CODE}) else $error("class code wrong");

	// Main scenarios reached
	cover property (cpu_req.wr && in_sys && write_unlocked);
	cover property (rq && in_f1);
	cover property (cpu_req.wr && in_fl && code_security_unit_open);
endmodule : pfd_frame_decoder_sva

// >>> pfd_frame_model.sv
// Behavioural model of the three peripheral frames behind the decoder
module pfd_frame_model
(
	// Clock
	input wire logic clock,
	// Frame requests
	input pfd_pkg::pfd_bus_s f0_bus,
	input pfd_pkg::pfd_bus_s f1_bus,
	input pfd_pkg::pfd_bus_s f2_bus,
	// Read replies
	output logic [31:0] f0_rdata,
	output logic [31:0] f1_rdata,
	output logic [15:0] f2_rdata
);
	logic [31:0] noise_reg = 32'h0;

	// Idle replies churn every cycle so a stale word never passes for data
	always_ff @(posedge clock)
		noise_reg <= noise_reg + 32'h9e3779b9;

	// Each frame answers in its strobe cycle with an address-keyed word
	assign f0_rdata = f0_bus.rd ? {f0_bus.addr[15:0], ~f0_bus.addr[15:0]}
		: noise_reg;
	assign f1_rdata = f1_bus.rd ? {~f1_bus.addr[15:0], f1_bus.addr[15:0]}
		: ~noise_reg;
	assign f2_rdata = f2_bus.rd ? f2_bus.addr[15:0] ^ 16'h5a5a
		: noise_reg[15:0];
endmodule : pfd_frame_model

// >>> pfd_frame_decoder_bench.sv
// Self-checking bench for the peripheral frame decoder
module pfd_frame_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// Arbitrary identity values
	localparam logic [15:0] P_PART = 16'h2a51;
	localparam logic [15:0] P_CLASS = 16'h0033;
	localparam logic [15:0] P_REV = 16'h0007;
	// Unprotected windows and two unmapped places; -1 means no frame
	localparam logic [21:0] RA [14] = '{22'h000c00, 22'h000ce0, 22'h000dff,
		22'h006400, 22'h00643f, 22'h006800, 22'h0068ff, 22'h006a00,
		22'h006fff, 22'h007040, 22'h00705f, 22'h007100, 22'h000100,
		22'h006500};
	localparam int RF [14] = '{0, 0, 0, 1, 1, 1, 1, 1, 1, 2, 2, 2, -1, -1};
	// Protected windows, frame 0 then frame 2
	localparam logic [21:0] PA [9] = '{22'h000984, 22'h000985, 22'h000987,
		22'h000ae0, 22'h000aef, 22'h007010, 22'h00702f, 22'h007060,
		22'h00707f};
	localparam int PF [9] = '{0, 0, 0, 0, 0, 2, 2, 2, 2};
	logic clock, sys_rst, cpu_ack, unl, rel, cso, write_unlocked, ack;
	pfd_pkg::pfd_req_s cpu_req;
	pfd_pkg::pfd_bus_s f0_bus, f1_bus, f2_bus;
	pfd_pkg::pfd_bus_s s [3];
	logic [31:0] cpu_rdata, f0_rdata, f1_rdata, device_config, rdv;
	logic [15:0] f2_rdata;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;

	// ---------------------------------------------------------------
	// Design, frame model and clock
	// ---------------------------------------------------------------
	pfd_frame_decoder #(.PART_CODE(P_PART), .CLASS_CODE(P_CLASS),
		.REVISION_CODE(P_REV)) DUT (.clock(clock), .sys_rst(sys_rst),
		.cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
		.write_unlock_instruction(unl), .write_relock_instruction(rel),
		.code_security_unit_open(cso), .f0_bus(f0_bus), .f0_rdata(f0_rdata),
		.f1_bus(f1_bus), .f1_rdata(f1_rdata), .f2_bus(f2_bus),
		.f2_rdata(f2_rdata), .write_unlocked(write_unlocked),
		.device_config(device_config));
	pfd_frame_model u_model (.clock(clock), .f0_bus(f0_bus),
		.f1_bus(f1_bus), .f2_bus(f2_bus), .f0_rdata(f0_rdata),
		.f1_rdata(f1_rdata), .f2_rdata(f2_rdata));
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// Compare, bus and helper tasks
	// ---------------------------------------------------------------
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask : chk_w
	task automatic chk_b(input logic got, input logic exp);
		chk_w({31'h0, got}, {31'h0, exp});
	endtask : chk_b
	// One request, frame strobes in cycle 1, answer in cycle 2
	// Strobes and ack stand one cycle only, so each is read just after
	// the edge that launches it
	task automatic bus_op(input logic w, input logic wd,
		input logic [21:0] a, input logic [31:0] d);
		@(posedge clock);
		cpu_req <= '{rd: !w, wr: w, wide: wd, addr: a, wdata: d};
		@(posedge clock);
		cpu_req <= '0;
		#1 s = '{f0_bus, f1_bus, f2_bus};
		@(posedge clock);
		#1 ack = cpu_ack;
		rdv = cpu_rdata;
	endtask : bus_op
	function automatic logic [31:0] exp_rd(int f, logic [21:0] a);
		case (f)
			0: return {a[15:0], ~a[15:0]};
			1: return {~a[15:0], a[15:0]};
			2: return {16'h0, a[15:0] ^ 16'h5a5a};
			default: return 32'h0;
		endcase
	endfunction : exp_rd
	// Access and judge which frame saw it and what came back
	task automatic xfer(input int f, input logic w, input logic wd,
		input logic [21:0] a, input logic [31:0] d, input logic [31:0] er);
		bus_op(w, wd, a, d);
		for (int k = 0; k < 3; k++)
			chk_b(s[k].rd | s[k].wr, k == f);
		if (f >= 0)
		begin
			chk_w({10'h0, s[f].addr}, {10'h0, a});
			chk_b(s[f].wr, w);
			if (w)
				chk_w(s[f].wdata, f == 2 ? {16'h0, d[15:0]} : d);
		end
		chk_b(ack, 1'b1);
		if (!w)
			chk_w(rdv, er);
	endtask : xfer
	task automatic pulse(input logic u, input logic r);
		@(posedge clock);
		unl <= u;
		rel <= r;
		@(posedge clock);
		unl <= 1'b0;
		rel <= 1'b0;
		#1;
	endtask : pulse

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_ident;
		chk_b(write_unlocked, 1'b0);
		chk_w(device_config, 32'h0);
		xfer(-1, 0, 0, pfd_pkg::CLASS_CODE_OFS, 0, {16'h0, P_CLASS});
		xfer(-1, 0, 0, pfd_pkg::REVISION_CODE_OFS, 0, {16'h0, P_REV});
		xfer(-1, 1, 0, pfd_pkg::PART_CODE_OFS, 32'hffff, 0);
		xfer(-1, 0, 0, pfd_pkg::PART_CODE_OFS, 0, {16'h0, P_PART});
	endtask : t_ident
	// Reads and locked writes of unprotected windows, both widths
	task automatic t_route;
		for (int w = 0; w < 2; w++)
			for (int i = 0; i < 14; i++)
				xfer(RF[i], w[0], i[0], RA[i], 32'hc0de0000 + i,
					exp_rd(RF[i], RA[i]));
	endtask : t_route
	task automatic t_prot;
		for (int i = 0; i < 9; i++)
			xfer(-1, 1, 0, PA[i], 32'h1111, 0);
		xfer(2, 0, 0, 22'h007010, 0, exp_rd(2, 22'h007010));
		pulse(1'b1, 1'b0);
		chk_b(write_unlocked, 1'b1);
		for (int i = 0; i < 9; i++)
			xfer(PF[i], 1, 1, PA[i], 32'h5aa50000 + i, 0);
		xfer(-1, 1, 0, 22'h000a80, 32'h77, 0);
		@(posedge clock) cso <= 1'b1;
		xfer(0, 1, 0, 22'h000adf, 32'h78, 0);
		xfer(-1, 1, 0, 22'h000b05, 32'h79, 0);
		xfer(0, 0, 0, 22'h000b0f, 0, exp_rd(0, 22'h000b0f));
		pulse(1'b1, 1'b1);
		chk_b(write_unlocked, 1'b0);
		xfer(-1, 1, 0, 22'h007060, 32'h7a, 0);
		xfer(-1, 1, 0, 22'h000adf, 32'h7b, 0);
	endtask : t_prot
	task automatic t_cfg;
		xfer(-1, 1, 1, pfd_pkg::DEVICE_CONFIG_OFS, 32'hffffffff, 0);
		chk_w(device_config, 32'h0);
		pulse(1'b1, 1'b0);
		xfer(-1, 1, 1, pfd_pkg::DEVICE_CONFIG_OFS, 32'h13579bdf, 0);
		chk_w(device_config, 32'h13579bdf);
		xfer(-1, 0, 1, 22'h000880, 0, 32'h13579bdf);
		xfer(-1, 0, 0, 22'h000881, 0, 32'h00001357);
		xfer(-1, 1, 0, 22'h000880, 32'h00002468, 0);
		chk_w(device_config, 32'h13572468);
		pulse(1'b0, 1'b1);
	endtask : t_cfg
	// Back-to-back reads answer in order, one per cycle
	task automatic t_b2b;
		@(posedge clock);
		cpu_req <= '{rd: 1, wr: 0, wide: 1, addr: 22'h006840, wdata: 0};
		@(posedge clock);
		cpu_req <= '{rd: 1, wr: 0, wide: 0, addr: 22'h007050, wdata: 0};
		@(posedge clock);
		cpu_req <= '0;
		#1 chk_b(cpu_ack, 1'b1);
		chk_w(cpu_rdata, exp_rd(1, 22'h006840));
		@(posedge clock);
		#1 chk_b(cpu_ack, 1'b1);
		chk_w(cpu_rdata, exp_rd(2, 22'h007050));
	endtask : t_b2b

	// ---------------------------------------------------------------
	// Sequence, timeout and verdict
	// ---------------------------------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	// A hang counts as a mismatch
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			conclude();
		end
	end
	initial
	begin
		sys_rst = 1'b1;
		cpu_req = '0;
		unl = 1'b0;
		rel = 1'b0;
		cso = 1'b0;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		#1 t_ident();
		t_route();
		t_prot();
		t_cfg();
		t_b2b();
		conclude();
	end
endmodule : pfd_frame_decoder_bench

bind pfd_frame_decoder pfd_frame_decoder_sva #(.PART_CODE(PART_CODE),
	.CLASS_CODE(CLASS_CODE), .REVISION_CODE(REVISION_CODE)) u_sva (
	.clock(clock), .sys_rst(sys_rst), .cpu_req(cpu_req),
	.cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
	.write_unlock_instruction(write_unlock_instruction),
	.write_relock_instruction(write_relock_instruction),
	.code_security_unit_open(code_security_unit_open), .f0_bus(f0_bus),
	.f0_rdata(f0_rdata), .f1_bus(f1_bus), .f1_rdata(f1_rdata),
	.f2_bus(f2_bus), .f2_rdata(f2_rdata), .write_unlocked(write_unlocked),
	.device_config(device_config));
